/* File: core/pgt_pkg.sv */
// Shared constants and carrier types for the power-good tree mask bank.
// Assumes one 100 MHz clock and a register port fed by the device's I2C slave.
`default_nettype none

package pgt_pkg;

  // Register offsets
  localparam logic [7:0] OUT3_GOOD_MASK_SECOND_OFS   = 8'hAB;
  localparam logic [7:0] MISC_CTRL_PIN_GOOD_MASK_OFS = 8'hAC;
  localparam logic [7:0] TERMINATION_DISCHARGE_OFS   = 8'hAD;

  // Field positions, second output-3 mask register
  localparam int CTRL_IN5_TREE_EXCLUDE_BIT    = 7;
  localparam int CTRL_IN4_TREE_EXCLUDE_BIT    = 6;
  localparam int CTRL_IN2_TREE_EXCLUDE_BIT    = 5;
  localparam int CTRL_IN1_TREE_EXCLUDE_BIT    = 4;
  localparam int TERM_LDO_TREE_EXCLUDE_BIT    = 3;
  localparam int SHARED_RAIL_TREE_EXCLUDE_BIT = 2;
  localparam int LOAD_SWITCH_B1_EXCLUDE_BIT   = 1;
  localparam int AUX_LDO3_TREE_EXCLUDE_BIT    = 0;

  // Field positions, miscellaneous control-pin mask register
  localparam int OUT3_CTRL_IN6_EXCLUDE_BIT = 7;
  localparam int OUT3_CTRL_IN3_EXCLUDE_BIT = 6;
  localparam int OUT2_CTRL_IN6_EXCLUDE_BIT = 5;
  localparam int OUT2_CTRL_IN3_EXCLUDE_BIT = 4;
  localparam int OUT4_CTRL_IN6_EXCLUDE_BIT = 3;
  localparam int OUT4_CTRL_IN3_EXCLUDE_BIT = 2;
  localparam int OUT1_CTRL_IN6_EXCLUDE_BIT = 1;
  localparam int OUT1_CTRL_IN3_EXCLUDE_BIT = 0;

  // Field position, termination discharge register
  localparam int TERM_DISCHARGE_SEL_BIT = 4;

  // Values held while reset is asserted: everything excluded, no discharge
  localparam logic [7:0] MASK_RESET_VALUE  = 8'hFF;
  localparam logic [7:0] DISCH_RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pgt_reg_req_t;

  // Factory configuration image for the three registers
  typedef struct packed {
    logic [7:0] out3_mask2;
    logic [7:0] misc_mask;
    logic [7:0] term_disch;
  } pgt_otp_t;

  // Asynchronous tree members: control pins and rail good flags
  typedef struct packed {
    logic ctrl_in6;
    logic ctrl_in5;
    logic ctrl_in4;
    logic ctrl_in3;
    logic ctrl_in2;
    logic ctrl_in1;
    logic term_good;
    logic shared_good;
    logic b1_good;
    logic ldo3_good;
  } pgt_pins_t;

  localparam int PINS_W = $bits(pgt_pins_t);

  typedef struct packed {
    logic good_output_4;
    logic good_output_3;
    logic good_output_2;
    logic good_output_1;
  } pgt_good_out_t;

endpackage

`default_nettype wire

/* File: core/pgt_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes inputs may change at any time relative to clk.
`default_nettype none

module pgt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // System clock
  input  wire logic             rst_b,  // Async reset, active low
  input  wire logic [WIDTH-1:0] din,    // Raw asynchronous inputs
  output logic      [WIDTH-1:0] dout    // Filtered synchronous level
);
  import pgt_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire  [WIDTH-1:0] next_dout = (agree & stage3) | (~agree & dout);

  // Stage one feeds stage two only; the filter looks at two and three
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout   <= next_dout;
    end
  end

endmodule

`default_nettype wire

/* File: core/pgt_mask_bank.sv */
// Power-good tree mask bank: three registers and the tree gating they steer.
// Assumes the I2C slave presents single-cycle read and write strobes, and that
// the factory configuration image is stable from reset release onward.
`default_nettype none

module pgt_mask_bank (
  input  wire logic                   clk,                // 100 MHz clock
  input  wire logic                   rst_b,              // Async reset, active low
  input  wire pgt_pkg::pgt_reg_req_t  reg_req,            // Register access from I2C slave
  output logic [7:0]                  reg_rdata,          // Read data, registered
  output logic                        reg_rvalid,         // Read data valid pulse
  input  wire pgt_pkg::pgt_otp_t      otp_cfg,            // Factory configuration image
  input  wire pgt_pkg::pgt_pins_t     tree_pins,          // Asynchronous tree members
  input  wire logic [3:0]             other_tree_good,    // Rest of each tree, outputs 4..1
  output pgt_pkg::pgt_good_out_t      good_out,           // Power-good outputs 4..1
  output logic                        term_discharge_sel, // Termination discharge on
  output logic                        cfg_loaded          // Factory image loaded
);
  import pgt_pkg::*;

  typedef enum logic {ST_LOAD, ST_RUN} pgt_state_t;

  pgt_state_t    state;
  logic [7:0]    out3_good_mask_second;
  logic [7:0]    misc_ctrl_pin_good_mask;
  logic [7:0]    termination_discharge_ctrl;
  pgt_pins_t     pins_f;
  logic [PINS_W-1:0] pins_vec;

  pgt_sync #(
    .WIDTH (PINS_W)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (tree_pins),
    .dout  (pins_vec)
  );

  assign pins_f = pgt_pins_t'(pins_vec);

  // Address decode
  wire hit_mask2 = (reg_req.addr == OUT3_GOOD_MASK_SECOND_OFS);
  wire hit_misc  = (reg_req.addr == MISC_CTRL_PIN_GOOD_MASK_OFS);
  wire hit_disch = (reg_req.addr == TERMINATION_DISCHARGE_OFS);
  wire running   = (state == ST_RUN);
  wire wr_mask2  = running && reg_req.wr && hit_mask2;
  wire wr_misc   = running && reg_req.wr && hit_misc;
  wire wr_disch  = running && reg_req.wr && hit_disch;

  logic [7:0] read_mux;
  always_comb
  begin
    if (hit_mask2)
      read_mux = out3_good_mask_second;
    else if (hit_misc)
      read_mux = misc_ctrl_pin_good_mask;
    else if (hit_disch)
      read_mux = termination_discharge_ctrl;
    else
      read_mux = UNMAPPED_READ;
  end

  // Reserved bits are stored as written; software must copy the factory values
  wire [7:0] next_disch = reg_req.wdata;

  // Async reset takes constants; the factory image is sampled on the first
  // edge after release, so a strap that settles late is still caught.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state                      <= ST_LOAD;
      out3_good_mask_second      <= MASK_RESET_VALUE;
      misc_ctrl_pin_good_mask    <= MASK_RESET_VALUE;
      termination_discharge_ctrl <= DISCH_RESET_VALUE;
    end
    else
    begin
      case (state)
        ST_LOAD:
        begin
          out3_good_mask_second      <= otp_cfg.out3_mask2;
          misc_ctrl_pin_good_mask    <= otp_cfg.misc_mask;
          termination_discharge_ctrl <= otp_cfg.term_disch;
          state                      <= ST_RUN;
        end
        ST_RUN:
        begin
          if (wr_mask2)
            out3_good_mask_second <= reg_req.wdata;
          if (wr_misc)
            misc_ctrl_pin_good_mask <= reg_req.wdata;
          if (wr_disch)
            termination_discharge_ctrl <= next_disch;
        end
        default:
          state <= ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= UNMAPPED_READ;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= running && reg_req.rd;
      if (running && reg_req.rd)
        reg_rdata <= read_mux;
    end
  end

  // A member passes when it is good or its exclude bit is set
  wire [7:0] m2 = out3_good_mask_second;
  wire [7:0] mc = misc_ctrl_pin_good_mask;
  wire pass_c5  = pins_f.ctrl_in5    | m2[CTRL_IN5_TREE_EXCLUDE_BIT];
  wire pass_c4  = pins_f.ctrl_in4    | m2[CTRL_IN4_TREE_EXCLUDE_BIT];
  wire pass_c2  = pins_f.ctrl_in2    | m2[CTRL_IN2_TREE_EXCLUDE_BIT];
  wire pass_c1  = pins_f.ctrl_in1    | m2[CTRL_IN1_TREE_EXCLUDE_BIT];
  wire pass_tt  = pins_f.term_good   | m2[TERM_LDO_TREE_EXCLUDE_BIT];
  wire pass_sh  = pins_f.shared_good | m2[SHARED_RAIL_TREE_EXCLUDE_BIT];
  wire pass_b1  = pins_f.b1_good     | m2[LOAD_SWITCH_B1_EXCLUDE_BIT];
  wire pass_l3  = pins_f.ldo3_good   | m2[AUX_LDO3_TREE_EXCLUDE_BIT];
  wire o3_c6    = pins_f.ctrl_in6    | mc[OUT3_CTRL_IN6_EXCLUDE_BIT];
  wire o3_c3    = pins_f.ctrl_in3    | mc[OUT3_CTRL_IN3_EXCLUDE_BIT];
  wire o2_c6    = pins_f.ctrl_in6    | mc[OUT2_CTRL_IN6_EXCLUDE_BIT];
  wire o2_c3    = pins_f.ctrl_in3    | mc[OUT2_CTRL_IN3_EXCLUDE_BIT];
  wire o4_c6    = pins_f.ctrl_in6    | mc[OUT4_CTRL_IN6_EXCLUDE_BIT];
  wire o4_c3    = pins_f.ctrl_in3    | mc[OUT4_CTRL_IN3_EXCLUDE_BIT];
  wire o1_c6    = pins_f.ctrl_in6    | mc[OUT1_CTRL_IN6_EXCLUDE_BIT];
  wire o1_c3    = pins_f.ctrl_in3    | mc[OUT1_CTRL_IN3_EXCLUDE_BIT];

  wire tree3 = pass_c5 & pass_c4 & pass_c2 & pass_c1 & pass_tt & pass_sh
             & pass_b1 & pass_l3 & o3_c6 & o3_c3;

  // Outputs held low until the factory masks are in place, so a glitch of
  // the reset-time all-excluded masks never reports power good.
  pgt_good_out_t next_good;
  always_comb
  begin
    next_good.good_output_1 = running & other_tree_good[0] & o1_c6 & o1_c3;
    next_good.good_output_2 = running & other_tree_good[1] & o2_c6 & o2_c3;
    next_good.good_output_3 = running & other_tree_good[2] & tree3;
    next_good.good_output_4 = running & other_tree_good[3] & o4_c6 & o4_c3;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      good_out <= '0;
    else
      good_out <= next_good;
  end

  assign term_discharge_sel = termination_discharge_ctrl[TERM_DISCHARGE_SEL_BIT];
  assign cfg_loaded         = running;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_load_edge;
    state == ST_LOAD;
  endsequence

  sequence s_run_stable;
    running [*2];
  endsequence

  a_load_factory_image: assert property (
    s_load_edge |=> (out3_good_mask_second == $past(otp_cfg.out3_mask2))
      && (misc_ctrl_pin_good_mask == $past(otp_cfg.misc_mask))
      && (termination_discharge_ctrl == $past(otp_cfg.term_disch))
  ) else $error("factory image not loaded after reset");

  a_ctrl5_gate_out3: assert property (
    s_run_stable ##0 (!m2[CTRL_IN5_TREE_EXCLUDE_BIT] && !pins_f.ctrl_in5)
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included control input 5 low");

  a_ctrl4_gate_out3: assert property (
    running && !m2[CTRL_IN4_TREE_EXCLUDE_BIT] && !pins_f.ctrl_in4
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included control input 4 low");

  a_ctrl2_gate_out3: assert property (
    running && !m2[CTRL_IN2_TREE_EXCLUDE_BIT] && !pins_f.ctrl_in2
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included control input 2 low");

  a_ctrl1_gate_out3: assert property (
    running && !m2[CTRL_IN1_TREE_EXCLUDE_BIT] && !pins_f.ctrl_in1
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included control input 1 low");

  a_term_gate_out3: assert property (
    running && !m2[TERM_LDO_TREE_EXCLUDE_BIT] && !pins_f.term_good
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included termination flag low");

  a_shared_gate_out3: assert property (
    running && !m2[SHARED_RAIL_TREE_EXCLUDE_BIT] && !pins_f.shared_good
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included shared rail low");

  a_b1_gate_out3: assert property (
    running && !m2[LOAD_SWITCH_B1_EXCLUDE_BIT] && !pins_f.b1_good
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included load switch B1 low");

  a_ldo3_gate_out3: assert property (
    running && !m2[AUX_LDO3_TREE_EXCLUDE_BIT] && !pins_f.ldo3_good
      |=> !good_out.good_output_3
  ) else $error("output 3 good with included LDO 3 low");

  a_misc_gate_out3: assert property (
    running && ((!mc[OUT3_CTRL_IN6_EXCLUDE_BIT] && !pins_f.ctrl_in6)
      || (!mc[OUT3_CTRL_IN3_EXCLUDE_BIT] && !pins_f.ctrl_in3))
      |=> !good_out.good_output_3
  ) else $error("output 3 ignores included input 6 or 3");

  a_misc_gate_out2: assert property (
    running && ((!mc[OUT2_CTRL_IN6_EXCLUDE_BIT] && !pins_f.ctrl_in6)
      || (!mc[OUT2_CTRL_IN3_EXCLUDE_BIT] && !pins_f.ctrl_in3))
      |=> !good_out.good_output_2
  ) else $error("output 2 ignores included input 6 or 3");

  a_misc_gate_out4: assert property (
    running && ((!mc[OUT4_CTRL_IN6_EXCLUDE_BIT] && !pins_f.ctrl_in6)
      || (!mc[OUT4_CTRL_IN3_EXCLUDE_BIT] && !pins_f.ctrl_in3))
      |=> !good_out.good_output_4
  ) else $error("output 4 ignores included input 6 or 3");

  a_misc_gate_out1: assert property (
    running && ((!mc[OUT1_CTRL_IN6_EXCLUDE_BIT] && !pins_f.ctrl_in6)
      || (!mc[OUT1_CTRL_IN3_EXCLUDE_BIT] && !pins_f.ctrl_in3))
      |=> !good_out.good_output_1
  ) else $error("output 1 ignores included input 6 or 3");

  a_masked_out1_good: assert property (
    running && other_tree_good[0] && mc[OUT1_CTRL_IN6_EXCLUDE_BIT]
      && mc[OUT1_CTRL_IN3_EXCLUDE_BIT] |=> good_out.good_output_1
  ) else $error("output 1 low with all members masked and rest good");

  a_write_then_read: assert property (
    wr_misc ##1 (reg_req.rd && hit_misc && !reg_req.wr)
      |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2)
  ) else $error("misc mask readback differs from written value");

  a_discharge_follows: assert property (
    wr_disch |=> term_discharge_sel == $past(reg_req.wdata[TERM_DISCHARGE_SEL_BIT])
  ) else $error("discharge select does not follow write");

  // The reset-time masks exclude everything, so a leak here would claim good
  a_load_outputs_low: assert property (
    s_load_edge |=> (good_out == '0)
  ) else $error("power good shown before factory masks loaded");

  a_masked_out2_good: assert property (
    running && other_tree_good[1] && mc[OUT2_CTRL_IN6_EXCLUDE_BIT]
      && mc[OUT2_CTRL_IN3_EXCLUDE_BIT] |=> good_out.good_output_2
  ) else $error("output 2 low with all members masked and rest good");

  a_masked_out4_good: assert property (
    running && other_tree_good[3] && mc[OUT4_CTRL_IN6_EXCLUDE_BIT]
      && mc[OUT4_CTRL_IN3_EXCLUDE_BIT] |=> good_out.good_output_4
  ) else $error("output 4 low with all members masked and rest good");

  a_masked_out3_good: assert property (
    running && other_tree_good[2] && (&m2) && mc[OUT3_CTRL_IN6_EXCLUDE_BIT]
      && mc[OUT3_CTRL_IN3_EXCLUDE_BIT] |=> good_out.good_output_3
  ) else $error("output 3 low with all members masked and rest good");

  a_read_returns_mask: assert property (
    running && reg_req.rd && hit_mask2 |=> reg_rvalid
      && (reg_rdata == $past(out3_good_mask_second))
  ) else $error("read of output 3 mask returns wrong data");

  a_unmapped_write_kept: assert property (
    running && reg_req.wr && !hit_mask2 && !hit_misc && !hit_disch
      |=> $stable(out3_good_mask_second) && $stable(misc_ctrl_pin_good_mask)
      && $stable(termination_discharge_ctrl)
  ) else $error("write to unmapped offset changed a register");

endmodule

`default_nettype wire

/* File: tb/pgt_pg_monitor.sv */
// Partner model: system logic that watches the power-good pins.
// Assumes the pins are levels in the same clock domain as the device.
`default_nettype none

module pgt_pg_monitor (
  input  wire logic                   clk,     // System clock
  input  wire logic                   rst_b,   // Async reset, active low
  input  wire pgt_pkg::pgt_good_out_t pg_pins, // Power-good pins from the device
  output pgt_pkg::pgt_good_out_t      pg_seen  // Level as latched by the system
);
  import pgt_pkg::*;

  // One flop only, like a real input register: a one-cycle glitch still shows
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      pg_seen <= '0;
    else
      pg_seen <= pg_pins;
endmodule

`default_nettype wire

/* File: tb/power_good_tree_masks_test.sv */
// Self-checking bench for the power-good tree mask bank.
// Assumes core/pgt_pkg.sv and the design modules are compiled first.
`default_nettype none

module power_good_tree_masks_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pgt_pkg::*;

  logic          clk             = 1'b0;
  logic          rst_b           = 1'b0;
  pgt_reg_req_t  reg_req         = '0;
  pgt_otp_t      otp_cfg         = '{8'hB7, 8'hE4, 8'h5F};
  pgt_pins_t     tree_pins       = '1;
  logic [3:0]    other_tree_good = 4'hF;
  logic [7:0]    reg_rdata;
  logic          reg_rvalid;
  pgt_good_out_t good_out;
  pgt_good_out_t pg_seen;
  logic          term_discharge_sel;
  logic          cfg_loaded;
  logic [7:0]    shadow_out3;
  logic [7:0]    shadow_misc;
  int            n_errors        = 0;
  int            check_count     = 0;
  int            pin_of[8]       = '{0, 1, 2, 3, 4, 5, 7, 8};

  always #5 clk = ~clk;

  pgt_mask_bank i_pgt_mask_bank (
    .clk                (clk),
    .rst_b              (rst_b),
    .reg_req            (reg_req),
    .reg_rdata          (reg_rdata),
    .reg_rvalid         (reg_rvalid),
    .otp_cfg            (otp_cfg),
    .tree_pins          (tree_pins),
    .other_tree_good    (other_tree_good),
    .good_out           (good_out),
    .term_discharge_sel (term_discharge_sel),
    .cfg_loaded         (cfg_loaded)
  );

  pgt_pg_monitor i_pgt_pg_monitor (
    .clk     (clk),
    .rst_b   (rst_b),
    .pg_pins (good_out),
    .pg_seen (pg_seen)
  );

  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] want, input string what);
    check_count++;
    if (got !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    if (a == OUT3_GOOD_MASK_SECOND_OFS)
      shadow_out3 = d;
    if (a == MISC_CTRL_PIN_GOOD_MASK_OFS)
      shadow_misc = d;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] want);
    int n;
    @(posedge clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4)
    begin
      n_errors++;
      $display("unexpected at %0t: no read answer", $time);
      conclude();
    end
    else
      check8(reg_rdata, want, "read data");
  endtask

  // Masked member counts as good; a tree is the AND of everything left in it
  function automatic pgt_good_out_t exp_good(input pgt_pins_t p);
    pgt_good_out_t e;
    e.good_output_1 = other_tree_good[0] & (shadow_misc[1] | p.ctrl_in6)
                      & (shadow_misc[0] | p.ctrl_in3);
    e.good_output_2 = other_tree_good[1] & (shadow_misc[5] | p.ctrl_in6)
                      & (shadow_misc[4] | p.ctrl_in3);
    e.good_output_4 = other_tree_good[3] & (shadow_misc[3] | p.ctrl_in6)
                      & (shadow_misc[2] | p.ctrl_in3);
    e.good_output_3 = other_tree_good[2] & (shadow_misc[7] | p.ctrl_in6)
                      & (shadow_misc[6] | p.ctrl_in3)
                      & (&(shadow_out3 | {p.ctrl_in5, p.ctrl_in4, p.ctrl_in2, p.ctrl_in1,
                                         p.term_good, p.shared_good, p.b1_good,
                                         p.ldo3_good}));
    return e;
  endfunction

  // Pin path is 5 edges plus the monitor flop; 7 leaves margin
  task automatic tree_check(input pgt_pins_t p, input logic [3:0] o);
    @(posedge clk);
    tree_pins <= p;
    other_tree_good <= o;
    repeat (7) @(posedge clk);
    #1;
    check8({4'h0, pg_seen}, {4'h0, exp_good(p)}, "good outputs");
  endtask

  task automatic t_reset_load();
    shadow_out3 = otp_cfg.out3_mask2;
    shadow_misc = otp_cfg.misc_mask;
    check8({7'h00, cfg_loaded}, 8'h01, "loaded flag");
    reg_read(OUT3_GOOD_MASK_SECOND_OFS, otp_cfg.out3_mask2);
    reg_read(MISC_CTRL_PIN_GOOD_MASK_OFS, otp_cfg.misc_mask);
    reg_read(TERMINATION_DISCHARGE_OFS, otp_cfg.term_disch);
    check8({7'h00, term_discharge_sel}, {7'h00, otp_cfg.term_disch[4]}, "disch");
    $display("done: reset load");
  endtask

  task automatic t_out3_members();
    pgt_pins_t p;
    reg_write(MISC_CTRL_PIN_GOOD_MASK_OFS, 8'hFF);
    for (int i = 0; i < 8; i++)
    begin
      p = '1;
      p[pin_of[i]] = 1'b0;
      reg_write(OUT3_GOOD_MASK_SECOND_OFS, ~(8'h01 << i));
      tree_check(p, 4'hF);
      reg_write(OUT3_GOOD_MASK_SECOND_OFS, 8'hFF);
      tree_check(p, 4'hF);
    end
    $display("done: output 3 members");
  endtask

  task automatic t_misc_members();
    pgt_pins_t p;
    for (int i = 0; i < 8; i++)
    begin
      p = '1;
      if (i % 2 == 0)
        p.ctrl_in3 = 1'b0;
      else
        p.ctrl_in6 = 1'b0;
      reg_write(MISC_CTRL_PIN_GOOD_MASK_OFS, ~(8'h01 << i));
      tree_check(p, 4'hF);
      reg_write(MISC_CTRL_PIN_GOOD_MASK_OFS, 8'hFF);
      tree_check(p, 4'hF);
    end
    $display("done: shared control members");
  endtask

  task automatic t_whole_tree();
    reg_write(OUT3_GOOD_MASK_SECOND_OFS, 8'h00);
    reg_write(MISC_CTRL_PIN_GOOD_MASK_OFS, 8'h00);
    tree_check('1, 4'hF);
    tree_check('1, 4'h5);
    tree_check(10'h2AA, 4'hF);
    reg_write(OUT3_GOOD_MASK_SECOND_OFS, 8'hFF);
    reg_write(MISC_CTRL_PIN_GOOD_MASK_OFS, 8'hFF);
    tree_check('0, 4'hF);
    $display("done: whole tree");
  endtask

  task automatic t_discharge_and_map();
    logic [7:0] keep;
    keep = otp_cfg.term_disch & 8'hEF;
    reg_write(TERMINATION_DISCHARGE_OFS, keep);
    #1;
    check8({7'h00, term_discharge_sel}, 8'h00, "disch off");
    reg_write(TERMINATION_DISCHARGE_OFS, keep | 8'h10);
    #1;
    check8({7'h00, term_discharge_sel}, 8'h01, "disch on");
    reg_read(TERMINATION_DISCHARGE_OFS, keep | 8'h10);
    reg_write(8'hAE, 8'h00);
    reg_read(8'hAE, UNMAPPED_READ);
    reg_read(OUT3_GOOD_MASK_SECOND_OFS, shadow_out3);
    $display("done: discharge and map");
  endtask

  // Write, read, then write and read together: the read must see the old value
  task automatic t_back_to_back();
    @(posedge clk);
    reg_req <= '{MISC_CTRL_PIN_GOOD_MASK_OFS, 8'h5A, 1'b1, 1'b0};
    @(posedge clk);
    reg_req <= '{MISC_CTRL_PIN_GOOD_MASK_OFS, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    reg_req <= '{MISC_CTRL_PIN_GOOD_MASK_OFS, 8'hA5, 1'b1, 1'b1};
    #1;
    check8({7'h00, reg_rvalid}, 8'h01, "read valid after write");
    check8(reg_rdata, 8'h5A, "read right after write");
    @(posedge clk);
    reg_req <= '{MISC_CTRL_PIN_GOOD_MASK_OFS, 8'hA5, 1'b0, 1'b0};
    #1;
    check8({7'h00, reg_rvalid}, 8'h01, "read valid with write");
    check8(reg_rdata, 8'h5A, "read beside write sees old");
    reg_read(MISC_CTRL_PIN_GOOD_MASK_OFS, 8'hA5);
    shadow_misc = 8'hA5;
    $display("done: back to back access");
  endtask

  // Second variant image; a write at the load edge must be dropped
  task automatic t_mid_reset();
    @(posedge clk);
    rst_b   <= 1'b0;
    otp_cfg <= '{8'hEB, 8'hEE, 8'h5C};
    repeat (2) @(posedge clk);
    #1;
    check8({4'h0, good_out}, 8'h00, "outputs in reset");
    check8({7'h00, cfg_loaded}, 8'h00, "loaded in reset");
    @(posedge clk);
    rst_b   <= 1'b1;
    reg_req <= '{OUT3_GOOD_MASK_SECOND_OFS, 8'h00, 1'b1, 1'b0};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
    t_reset_load();
    tree_check(10'h3FB, 4'hF);
    $display("done: mid-run reset");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset_load();
    t_out3_members();
    t_misc_members();
    t_whole_tree();
    t_discharge_and_map();
    t_back_to_back();
    t_mid_reset();
    conclude();
  end

  initial
  begin
    #200us;
    n_errors++;
    $display("unexpected at %0t: run limit reached", $time);
    conclude();
  end
endmodule

`default_nettype wire
